/* pkg/ppms_pkg.sv */
// Package for the port pin mode select block: types and constants
package ppms_pkg;
   // ----------------------------------------
   // Host bus types
   // ----------------------------------------
   typedef enum logic [1:0] {
      HOST_XA8,
      HOST_PAGED,
      HOST_MUX8,
      HOST_NONMUX8
   } ppms_host_t;

   // ----------------------------------------
   // Widths and reset values
   // ----------------------------------------
   localparam int PPMS_PORT_W = 8;
   localparam int PPMS_PORTD_W = 3;
   localparam int PPMS_PIO_BIT = 7;
   localparam logic [7:0] PPMS_RST_BYTE = 8'h00;
   localparam logic [2:0] PPMS_RST_D = 3'h0;
   localparam logic [15:0] PPMS_RST_ADDR = 16'h0000;
   localparam logic [7:0] PPMS_OE_OFF8 = 8'hff;
   localparam logic [2:0] PPMS_OE_OFF3 = 3'h7;
   localparam logic [26:0] PPMS_RST_SYNC = 27'h000_0000;
   localparam logic [2:0] PPMS_RST_STROBE = 3'h0;

   // Per-port pin group: output value and active-low enable
   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oeN;
   } ppms_pins8_t;

   typedef struct packed {
      logic [2:0] out;
      logic [2:0] oeN;
   } ppms_pins3_t;

   // Configuration that the host writes at run time
   typedef struct packed {
      logic [7:0] ctlA;
      logic [7:0] ctlB;
      logic [7:0] dirA;
      logic [7:0] dirB;
      logic [7:0] dirC;
      logic [2:0] dirD;
      logic [7:0] doutA;
      logic [7:0] doutB;
      logic [7:0] doutC;
      logic [2:0] doutD;
   } ppms_cfg_t;
endpackage : ppms_pkg

/* rtl/ppms_port_pin_mode_select.sv */
// Port pin mode select: output steering and input capture for ports A-D
`timescale 1ns/1ps
module ppms_port_pin_mode_select
   import ppms_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Host bus
   input wire ppms_host_t hostType,
   input wire logic addrStrobe,
   input wire logic [15:0] hostAddr,
   input wire logic [7:0] hostDataOut,
   input wire logic hostDataDrive,
   input wire ppms_cfg_t cfg,
   input wire logic [7:0] memory_map_register,
   // Logic block side
   input wire logic [7:0] macrocell_group_first,
   input wire logic [7:0] macrocell_group_second,
   input wire logic [2:0] extChipSel,
   input wire logic [7:0] logicOutSelA,
   input wire logic [7:0] logicOutSelB,
   input wire logic [7:0] logicOutSelC,
   input wire logic [2:0] logicOutSelD,
   input wire logic [7:0] oeTermA,
   input wire logic [7:0] oeTermB,
   input wire logic [7:0] oeTermC,
   input wire logic [2:0] oeTermD,
   input wire logic periph_select_zero,
   input wire logic periph_select_one,
   // Scan enables
   input wire logic scan_select_logic,
   input wire logic scanConfig,
   input wire logic scanEnablePin,
   // Pins
   input wire logic [7:0] pinInA,
   input wire logic [7:0] pinInB,
   input wire logic [7:0] pinInC,
   input wire logic [2:0] pinInD,
   output ppms_pins8_t portA,
   output ppms_pins8_t portB,
   output ppms_pins8_t portC,
   output ppms_pins3_t portD,
   // Readback
   output logic [7:0] dataInA,
   output logic [7:0] dataInB,
   output logic [7:0] dataInC,
   output logic [2:0] dataInD,
   output logic [15:0] latchedAddr,
   output logic scanActive
);
   // ----------------------------------------
   // Address mapping
   // ----------------------------------------
   // Returns {portB, portA} address bytes and valid nibble mask
   function automatic logic [19:0] addrMap(input ppms_host_t h, input logic [15:0] a);
      logic [19:0] r;
      r = 20'h0_0000;
      // Mask bits high to low: B upper, B lower, A upper, A lower
      case (h)
         HOST_XA8: r = {4'b0110, 4'h0, a[11:8], a[7:4], 4'h0};
         HOST_PAGED: r = {4'b1100, a[15:12], a[11:8], 8'h00};
         HOST_MUX8: r = {4'b1111, a[7:0], a[7:0]};
         default: r = {4'b1100, a[7:0], 8'h00};
      endcase
      return r;
   endfunction : addrMap

   // Expands nibble mask to pin mask
   function automatic logic [7:0] nibMask(input logic [1:0] m);
      return {{4{m[1]}}, {4{m[0]}}};
   endfunction : nibMask

   // ----------------------------------------
   // Input synchronisers
   // ----------------------------------------
   // Pins come from outside, so two flops before any use
   logic [26:0] syncOne, syncTwo, next_syncOne, next_syncTwo;
   logic [2:0] strobeSync, next_strobeSync;
   logic [15:0] addrSyncOne, addrSyncTwo, next_addrSyncOne, next_addrSyncTwo;
   logic [15:0] next_latchedAddr;

   always_comb begin
      next_syncOne = {pinInD, pinInC, pinInB, pinInA};
      next_syncTwo = syncOne;
      next_strobeSync = {strobeSync[1:0], addrStrobe};
      next_addrSyncOne = hostAddr;
      next_addrSyncTwo = addrSyncOne;
      next_latchedAddr = latchedAddr;
      // Address must hold steady over the strobe fall, no handshake
      if (strobeSync[2] && !strobeSync[1]) begin
         next_latchedAddr = addrSyncTwo;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         syncOne <= PPMS_RST_SYNC;
         syncTwo <= PPMS_RST_SYNC;
         strobeSync <= PPMS_RST_STROBE;
         addrSyncOne <= PPMS_RST_ADDR;
         addrSyncTwo <= PPMS_RST_ADDR;
         latchedAddr <= PPMS_RST_ADDR;
      end else begin
         syncOne <= next_syncOne;
         syncTwo <= next_syncTwo;
         strobeSync <= next_strobeSync;
         addrSyncOne <= next_addrSyncOne;
         addrSyncTwo <= next_addrSyncTwo;
         latchedAddr <= next_latchedAddr;
      end
   end

   // ----------------------------------------
   // Output steering
   // ----------------------------------------
   ppms_pins8_t next_portA, next_portB, next_portC;
   ppms_pins3_t next_portD;
   logic next_scanActive;
   logic [19:0] map;
   logic [7:0] aoA, aoB, enA, enB, enC, selA, selB, srcA, srcB;
   logic [2:0] enD;
   logic pioOn;
   logic [7:0] next_dataInA, next_dataInB, next_dataInC;
   logic [2:0] next_dataInD;

   always_comb begin
      map = addrMap(hostType, latchedAddr);
      aoA = cfg.ctlA & nibMask(map[17:16]);
      aoB = cfg.ctlB & nibMask(map[19:18]);
      enA = cfg.dirA | oeTermA;
      enB = cfg.dirB | oeTermB;
      enC = cfg.dirC | oeTermC;
      enD = cfg.dirD | oeTermD;
      // Group one only on A, both groups on B
      selA = logicOutSelA;
      selB = logicOutSelB;
      srcA = macrocell_group_first;
      srcB = macrocell_group_first;
      for (int i = 0; i < PPMS_PORT_W; i++) begin
         if (selA[i]) srcA[i] = macrocell_group_first[i];
         if (selB[i] && oeTermB[i]) srcB[i] = macrocell_group_second[i];
      end
      // Address is shown where the enable term or dir and ctl agree
      next_portA.out = cfg.doutA;
      next_portB.out = cfg.doutB;
      for (int i = 0; i < PPMS_PORT_W; i++) begin
         if (aoA[i] && (oeTermA[i] || cfg.dirA[i])) next_portA.out[i] = map[i];
         else if (selA[i]) next_portA.out[i] = srcA[i];
         if (aoB[i] && (oeTermB[i] || cfg.dirB[i])) next_portB.out[i] = map[8 + i];
         else if (selB[i]) next_portB.out[i] = srcB[i];
      end
      next_portA.oeN = ~enA;
      next_portB.oeN = ~enB;
      pioOn = memory_map_register[PPMS_PIO_BIT];
      if (pioOn) begin
         // Whole port A follows host data, off when no select is live
         next_portA.out = hostDataOut;
         next_portA.oeN = ~{8{(periph_select_zero | periph_select_one) & hostDataDrive}};
      end
      next_portC.out = (cfg.doutC & ~logicOutSelC) | (macrocell_group_second & logicOutSelC);
      next_portC.oeN = ~enC;
      next_scanActive = scan_select_logic | scanConfig | scanEnablePin;
      if (next_scanActive) begin
         // Scan owns port C whenever any of the three scan enables is set, normal steering otherwise
         next_portC.oeN = PPMS_OE_OFF8;
      end
      next_portD.out = (cfg.doutD & ~logicOutSelD) | (extChipSel & logicOutSelD);
      next_portD.oeN = ~enD;
      // Readback shows the pin itself, so a driven pin reads its own level
      next_dataInA = syncTwo[7:0];
      next_dataInB = syncTwo[15:8];
      next_dataInC = syncTwo[23:16];
      next_dataInD = syncTwo[26:24];
   end

   // ----------------------------------------
   // Output registers
   // ----------------------------------------
   always_ff @(posedge clk) begin
      if (rst) begin
         portA <= '{out: PPMS_RST_BYTE, oeN: PPMS_OE_OFF8};
         portB <= '{out: PPMS_RST_BYTE, oeN: PPMS_OE_OFF8};
         portC <= '{out: PPMS_RST_BYTE, oeN: PPMS_OE_OFF8};
         portD <= '{out: PPMS_RST_D, oeN: PPMS_OE_OFF3};
         scanActive <= 1'b0;
         dataInA <= PPMS_RST_BYTE;
         dataInB <= PPMS_RST_BYTE;
         dataInC <= PPMS_RST_BYTE;
         dataInD <= PPMS_RST_D;
      end else begin
         portA <= next_portA;
         portB <= next_portB;
         portC <= next_portC;
         portD <= next_portD;
         scanActive <= next_scanActive;
         dataInA <= next_dataInA;
         dataInB <= next_dataInB;
         dataInC <= next_dataInC;
         dataInD <= next_dataInD;
      end
   end
endmodule : ppms_port_pin_mode_select

/* tb/ppms_chk.sv */
// Checker: pin steering assertions for the port pin mode select block
`timescale 1ns/1ps
module ppms_chk
   import ppms_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Inputs watched
   input wire ppms_host_t hostType,
   input wire logic addrStrobe,
   input wire logic [15:0] hostAddr,
   input wire logic [7:0] hostDataOut,
   input wire logic hostDataDrive,
   input wire ppms_cfg_t cfg,
   input wire logic [7:0] memory_map_register,
   input wire logic [7:0] oeTermB,
   input wire logic [2:0] oeTermD,
   input wire logic periph_select_zero,
   input wire logic scan_select_logic,
   input wire logic scanConfig,
   input wire logic scanEnablePin,
   // Outputs watched
   input wire ppms_pins8_t portA,
   input wire ppms_pins8_t portB,
   input wire ppms_pins8_t portC,
   input wire ppms_pins3_t portD,
   input wire logic [15:0] latchedAddr,
   input wire logic scanActive
);
   // Past-value checks only once the edge before was out of reset
   logic wasUp;
   always_ff @(posedge clk) wasUp <= !rst;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   AST_OE_B: assert property (wasUp |-> portB.oeN == ~$past(cfg.dirB | oeTermB))
      else $error("port B enable wrong");
   AST_OE_D: assert property (wasUp |-> portD.oeN == ~$past(cfg.dirD | oeTermD))
      else $error("port D enable wrong");
   AST_SCAN: assert property (wasUp && $past(scan_select_logic | scanConfig | scanEnablePin)
      |-> scanActive && portC.oeN == 8'hff)
      else $error("scan not active");
   AST_LATCH: assert property ($fell(addrStrobe) |-> ##[3:8] latchedAddr == hostAddr)
      else $error("address not latched");
   AST_ADDR_NONMUX: assert property (wasUp && $past(hostType == HOST_NONMUX8 &&
      cfg.ctlB == 8'hff && cfg.dirB == 8'hff) && $stable(latchedAddr)
      |-> portB.out == latchedAddr[7:0]) else $error("port B address wrong");
   AST_ADDR_PAGED: assert property (wasUp && $past(hostType == HOST_PAGED &&
      cfg.ctlB == 8'hff && cfg.dirB == 8'hff) && $stable(latchedAddr)
      |-> portB.out == latchedAddr[15:8]) else $error("paged address wrong");
   AST_ADDR_MUX: assert property (wasUp && $past(hostType == HOST_MUX8 &&
      cfg.ctlA == 8'hff && cfg.dirA == 8'hff && !memory_map_register[7])
      && $stable(latchedAddr) |-> portA.out == latchedAddr[7:0]) else $error("port A address wrong");
   AST_PERIPH: assert property (wasUp && $past(memory_map_register[7] & periph_select_zero
      & hostDataDrive) |-> portA.oeN == 8'h00 && portA.out == $past(hostDataOut))
      else $error("data buffer wrong");
endmodule : ppms_chk

bind ppms_port_pin_mode_select ppms_chk i_chk (.*);

/* tb/ppms_pin_model.sv */
// Far-side pin model: resolves a port wire from the driver and the outside level
`timescale 1ns/1ps
module ppms_pin_model #(parameter int W = 8) (
   // Design side
   input wire logic [W-1:0] out,
   input wire logic [W-1:0] oeN,
   // Outside world
   input wire logic [W-1:0] ext,
   output logic [W-1:0] pin
);
   // Undriven pins follow the outside level, no keeper
   assign pin = (out & ~oeN) | (ext & oeN);
endmodule : ppms_pin_model

/* tb/ppms_port_pin_mode_select_tb.sv */
// Testbench for the port pin mode select block
`timescale 1ns/1ps
module ppms_port_pin_mode_select_tb
   import ppms_pkg::*;
();
   logic clk, rst, addrStrobe, hostDataDrive, periph_select_zero, periph_select_one;
   logic scan_select_logic, scanConfig, scanEnablePin;
   ppms_host_t hostType;
   ppms_cfg_t cfg;
   logic [15:0] hostAddr, latchedAddr;
   logic [7:0] hostDataOut, memory_map_register, macrocell_group_first, macrocell_group_second;
   logic [7:0] logicOutSelA, logicOutSelB, logicOutSelC, oeTermA, oeTermB, oeTermC;
   logic [7:0] pinInA, pinInC, extB, dataInA, dataInB, dataInC;
   logic [2:0] extChipSel, logicOutSelD, oeTermD, extD, dataInD;
   wire logic [7:0] pinInB;
   wire logic [2:0] pinInD;
   ppms_pins8_t portA, portB, portC;
   ppms_pins3_t portD;
   logic scanActive;
   logic [15:0] expAB [4] = '{16'hc005, 16'h00a5, 16'hc3c3, 16'h00c3};
   int n_mismatch = 0;
   int tests_run = 0;
   ppms_port_pin_mode_select i_dut (.*);
   ppms_pin_model #(.W(8)) i_pinB (.out(portB.out), .oeN(portB.oeN), .ext(extB), .pin(pinInB));
   ppms_pin_model #(.W(3)) i_pinD (.out(portD.out), .oeN(portD.oeN), .ext(extD), .pin(pinInD));
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : step
   task automatic give_verdict();
      if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : give_verdict
   initial begin
      clk = 0;
      forever #25 clk = ~clk;
   end
   initial begin
      #50000;
      n_mismatch++;
      give_verdict();
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      rst = 1;
      {addrStrobe, hostDataDrive, periph_select_zero, periph_select_one} = '0;
      {scan_select_logic, scanConfig, scanEnablePin, hostAddr, hostDataOut} = '0;
      {memory_map_register, macrocell_group_first, macrocell_group_second, extChipSel} = '0;
      {logicOutSelA, logicOutSelB, logicOutSelC, logicOutSelD, oeTermA, oeTermB} = '0;
      {oeTermC, oeTermD, pinInA, pinInC, extB, extD} = '0;
      cfg = '0;
      hostType = HOST_MUX8;
      step(16);
      rst = 0;
      step(1);
      chk("reset", {portB.oeN, latchedAddr[7:0]}, 16'hff00);
      for (int i = 0; i < 4; i++) begin
         cfg.dirD = {3{i[0]}};
         oeTermD = {3{i[1]}};
         step(2);
         chk("D enable", portD.oeN, (i == 0) ? 3'h7 : 3'h0);
      end
      // Logic-input pins keep direction 0; the outside level must read back
      {cfg.dirD, oeTermD, extD} = {3'h0, 3'h0, 3'h5};
      step(5);
      chk("D float", {portD.oeN, dataInD}, 6'h3d);
      {cfg.dirD, cfg.doutD, pinInA, pinInC} = {3'h7, 3'h6, 16'h9669};
      step(5);
      chk("D host out", dataInD, 3'h6);
      chk("A C in", {dataInA, dataInC}, 16'h9669);
      {logicOutSelD, extChipSel, logicOutSelC, macrocell_group_second} = {3'h7, 3'h5, 16'hff3c};
      {logicOutSelA, macrocell_group_first, cfg.dirA, cfg.dirC} = 32'hffc3_ffff;
      step(2);
      chk("logic out", {portD.out, portA.out, portC.out}, 19'h5_c33c);
      {logicOutSelA, cfg.dirA} = '0;
      for (int i = 0; i < 3; i++) begin
         {scan_select_logic, scanConfig, scanEnablePin} = 3'h1 << i;
         step(2);
         chk("scan", {scanActive, portC.oeN}, 9'h1ff);
      end
      {scan_select_logic, scanConfig, scanEnablePin} = '0;
      {hostAddr, addrStrobe} = {16'ha5c3, 1'b1};
      step(3);
      addrStrobe = 0;
      step(8);
      chk("latch", latchedAddr, 16'ha5c3);
      {cfg.ctlA, cfg.ctlB, cfg.dirA, cfg.dirB} = 32'hffff_ffff;
      for (int i = 0; i < 4; i++) begin
         hostType = ppms_host_t'(i);
         step(2);
         chk("addr map", {portA.out, portB.out}, expAB[i]);
      end
      cfg.dirB = 8'h00;
      step(2);
      chk("addr off", portB.oeN, 8'hff);
      oeTermB = 8'hff;
      step(5);
      chk("addr term", {portB.oeN, dataInB}, 16'h00c3);
      {memory_map_register, periph_select_zero, hostDataDrive, hostDataOut} = 18'h2_035a;
      step(2);
      chk("periph", {portA.oeN, portA.out}, 16'h005a);
      periph_select_zero = 0;
      step(2);
      chk("periph off", portA.oeN, 8'hff);
      give_verdict();
   end
endmodule : ppms_port_pin_mode_select_tb
